// >>> inc/i2cs_consts.svh
// Overview of operation
// - stop sets address/stop flag when enabled
// - promiscuous match accepts every address
// - otherwise only own address matches
// - auto-continue: command or data access resumes
// - no auto-continue: only command resumes
// - slave works only while enable bit set
// - ack choice bit: 0 ACK, 1 NACK
// - command field is strobe, reads zero
// - finish command: ack if write, then wait start
// - reply after address: ack, receive or data irq
// - reply after data: ack/receive or read byte
// - ack choice and command in one write
// - data done on byte received, byte sent or read address ack
// - flags cleared by w1c, auto-continue data access, command
// - address/stop flag on match or stop
// - stretch SCL while data done or address-match flag pending, not on stop flag
// - last received ack readable
// - collision flag, never drive SDA low on sent data bits after (ack bits still driven)
// - collision cleared by w1c or start
// - bus error on illegal start/stop, w1c
// - direction bit from last address
// - cause bit: 0 stop, 1 address
// - data irq when enable and data done
`ifndef I2CS_CONSTS_SVH
`define I2CS_CONSTS_SVH
`define I2CS_OFS_SETUP    4'h9
`define I2CS_OFS_CMDCTL   4'hA
`define I2CS_OFS_FLAGS    4'hB
`define I2CS_OFS_OWNADDR  4'hC
`define I2CS_OFS_DATA     4'hD
`define I2CS_SETUP_RST    8'h00
`define I2CS_ADDR_RST     8'h00
`define I2CS_BIT_ENABLE   0
`define I2CS_BIT_AUTOCONT 1
`define I2CS_BIT_PROMISC  2
`define I2CS_BIT_STOPEN   5
`define I2CS_BIT_AIEN     6
`define I2CS_BIT_DATA_IRQ_ENABLE     7
`define I2CS_BIT_ACKCH    2
`define I2CS_BIT_DDONE    7
`define I2CS_BIT_ASTOP    6
`define I2CS_BIT_CLASH    3
`define I2CS_BIT_ILLEGAL_CONDITION_FLAG   2
`endif

// >>> inc/i2cs_pkg.sv
package i2cs_pkg;
   typedef enum logic [1:0] {
      I2CS_CMD_NOP    = 2'b00,
      I2CS_CMD_RSVD   = 2'b01,
      I2CS_CMD_FINISH = 2'b10,
      I2CS_CMD_REPLY  = 2'b11
   } i2cs_cmd_e;
   typedef enum logic [2:0] {
      I2CS_ST_IDLE  = 3'b000,
      I2CS_ST_ADDR  = 3'b001,
      I2CS_ST_RX    = 3'b010,
      I2CS_ST_TX    = 3'b011,
      I2CS_ST_ACKO  = 3'b100,
      I2CS_ST_ACKI  = 3'b101,
      I2CS_ST_HOLD  = 3'b110
   } i2cs_state_e;
   typedef logic [3:0] i2cs_addr_t;
endpackage

// >>> rtl/i2cs_slave.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "i2cs_consts.svh"
module i2cs_slave
(
   // clock, reset, enable
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst_n,
   input  wire logic              i_ce,
   // register port
   input  wire i2cs_pkg::i2cs_addr_t i_addr,
   input  wire logic [7:0]        i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic [7:0]             o_rdata,
   // bus lines
   input  wire logic              i_scl,
   input  wire logic              i_sda,
   output logic                   o_scl,
   output logic                   o_scl_oe,
   output logic                   o_sda,
   output logic                   o_sda_oe,
   // interrupts toward the core and master enable
   input  wire logic              i_master_en,
   output logic                   o_data_irq,
   output logic                   o_addr_stop_irq
);
   import i2cs_pkg::*;

   // synchronisers and history
   logic [1:0] scl_sync_ff;
   logic [1:0] sda_sync_ff;
   logic       scl_d_ff;
   logic       sda_d_ff;
   // registers
   logic [7:0] setup_ff;
   logic [7:0] own_address_ff;
   logic       ack_choice_ff;
   logic       data_done_flag_ff;
   logic       addr_stop_flag_ff;
   logic       last_ack_seen_ff;
   logic       transmit_clash_flag_ff;
   logic       illegal_condition_flag_ff;
   logic       dir_ff;
   logic       flag_cause_bit_ff;
   logic [7:0] shift_ff;
   logic [3:0] bit_cnt_ff;
   logic       drive_low_ff;
   logic       hold_after_data_ff;
   i2cs_state_e state_ff;

   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic enabled;
   logic stretch;
   logic cmd_wr;
   logic data_acc;
   logic resume;
   logic eff_ack;
   logic addr_match;
   logic [7:0] flags;
   i2cs_cmd_e cmd_code;

   // helper strobes and events
   logic       flag_wr;
   logic       clr_irq;
   logic       bus_err_ev;
   logic [7:0] tx_byte;

   // two-stage sync of pins then one history stage
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
         scl_d_ff    <= 1'b1;
         sda_d_ff    <= 1'b1;
      end
      else if (i_ce)
      begin
         scl_sync_ff <= {scl_sync_ff[0], i_scl};
         sda_sync_ff <= {sda_sync_ff[0], i_sda};
         scl_d_ff    <= scl_sync_ff[1];
         sda_d_ff    <= sda_sync_ff[1];
      end
   end

   // bus events from synchronised lines
   assign scl_s    = scl_sync_ff[1];
   assign sda_s    = sda_sync_ff[1];
   assign scl_rise = scl_s & ~scl_d_ff;
   assign scl_fall = ~scl_s & scl_d_ff;
   assign start_ev = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   assign stop_ev  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

   // register access decode
   assign enabled  = setup_ff[`I2CS_BIT_ENABLE];
   assign cmd_code = i2cs_cmd_e'(i_wdata[1:0]);
   assign cmd_wr   = i_wr & (i_addr == `I2CS_OFS_CMDCTL)
                     & (cmd_code[1] == 1'b1);
   assign data_acc = (i_wr | i_rd) & (i_addr == `I2CS_OFS_DATA);
   assign resume   = cmd_wr | (data_acc & setup_ff[`I2CS_BIT_AUTOCONT]);
   // ack choice written with the command applies at once
   assign eff_ack  = (i_wr & (i_addr == `I2CS_OFS_CMDCTL)) ?
                     i_wdata[`I2CS_BIT_ACKCH] : ack_choice_ff;
   assign addr_match = setup_ff[`I2CS_BIT_PROMISC] ? 1'b1 :
                       (shift_ff[7:1] == own_address_ff[7:1]);
   assign stretch  = data_done_flag_ff | (addr_stop_flag_ff & flag_cause_bit_ff);

   // flag register write strobe for write-one-to-clear
   assign flag_wr  = i_wr & (i_addr == `I2CS_OFS_FLAGS);
   // pending interrupt released by what also resumes the bus, or by a flag w1c
   assign clr_irq  = resume;
   // first transmit bit: a data write in this cycle is the byte to send
   assign tx_byte  = (i_wr && i_addr == `I2CS_OFS_DATA && stretch) ? i_wdata : shift_ff;

   // illegal bus conditions: stop inside the address byte,
   // start or stop part way through a data byte
   assign bus_err_ev = i_master_en
                       & ((stop_ev & (state_ff == I2CS_ST_ADDR))
                          | ((start_ev | stop_ev) & (bit_cnt_ff != 4'h0)
                             & ((state_ff == I2CS_ST_RX) | (state_ff == I2CS_ST_TX))));

   // setup, own address and ack choice registers
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         setup_ff       <= `I2CS_SETUP_RST;
         own_address_ff <= `I2CS_ADDR_RST;
         ack_choice_ff  <= 1'b0;
      end
      else if (i_ce && i_wr)
      begin
         if (i_addr == `I2CS_OFS_SETUP)
            setup_ff <= i_wdata & 8'hE7;
         if (i_addr == `I2CS_OFS_OWNADDR)
            own_address_ff <= i_wdata;
         if (i_addr == `I2CS_OFS_CMDCTL)
            ack_choice_ff <= i_wdata[`I2CS_BIT_ACKCH];
      end
   end

   // protocol engine
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_ff           <= I2CS_ST_IDLE;
         shift_ff           <= 8'h00;
         bit_cnt_ff         <= 4'h0;
         drive_low_ff       <= 1'b0;
         dir_ff             <= 1'b0;
         last_ack_seen_ff   <= 1'b0;
         hold_after_data_ff <= 1'b0;
      end
      else if (i_ce)
      begin
         // data register loads only while the clock is held
         if (i_wr && i_addr == `I2CS_OFS_DATA && stretch)
            shift_ff <= i_wdata;                             // load only under hold
         if (!enabled || stop_ev)
         begin
            state_ff     <= I2CS_ST_IDLE;
            drive_low_ff <= 1'b0;
         end
         else if (start_ev)
         begin
            state_ff     <= I2CS_ST_ADDR;
            bit_cnt_ff   <= 4'h0;
            drive_low_ff <= 1'b0;
         end
         else
         begin
            case (state_ff)
               I2CS_ST_ADDR, I2CS_ST_RX:
               begin
                  if (scl_rise)
                  begin
                     shift_ff   <= {shift_ff[6:0], sda_s};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
                  else if (scl_fall && bit_cnt_ff == 4'h8)
                  begin
                     bit_cnt_ff <= 4'h0;
                     if (state_ff == I2CS_ST_ADDR)
                     begin
                        if (addr_match)
                        begin
                           dir_ff             <= shift_ff[0];
                           hold_after_data_ff <= 1'b0;
                           state_ff           <= I2CS_ST_HOLD;
                        end
                        else
                           state_ff <= I2CS_ST_IDLE;
                     end
                     else
                     begin
                        hold_after_data_ff <= 1'b1;
                        state_ff           <= I2CS_ST_HOLD;
                     end
                  end
               end
               I2CS_ST_HOLD:
               begin
                  // software resumes; ack chosen now
                  if (resume && cmd_wr && cmd_code == I2CS_CMD_FINISH)
                  begin
                     drive_low_ff <= ~dir_ff & ~eff_ack;
                     state_ff     <= dir_ff ? I2CS_ST_IDLE : I2CS_ST_ACKO;
                     bit_cnt_ff   <= 4'hF;                   // finish after ack
                  end
                  else if (resume)
                  begin
                     if (dir_ff && hold_after_data_ff)
                     begin
                        state_ff     <= I2CS_ST_TX;
                        drive_low_ff <= ~tx_byte[7] & ~transmit_clash_flag_ff;
                        bit_cnt_ff   <= 4'h0;
                     end
                     else
                     begin
                        drive_low_ff <= ~eff_ack;
                        state_ff     <= I2CS_ST_ACKO;
                        bit_cnt_ff   <= 4'h0;
                     end
                  end
               end
               I2CS_ST_ACKO:
               begin
                  if (scl_fall)
                  begin
                     drive_low_ff <= 1'b0;
                     if (bit_cnt_ff == 4'hF || eff_ack)
                        state_ff <= I2CS_ST_IDLE;           // wait for start
                     else if (dir_ff)
                        state_ff <= I2CS_ST_HOLD;           // read: data irq next
                     else
                        state_ff <= I2CS_ST_RX;
                     hold_after_data_ff <= 1'b1;
                     bit_cnt_ff <= 4'h0;
                  end
               end
               I2CS_ST_TX:
               begin
                  if (scl_fall)
                  begin
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                     shift_ff   <= {shift_ff[6:0], 1'b1};
                     if (bit_cnt_ff == 4'h7)
                     begin
                        drive_low_ff <= 1'b0;
                        state_ff     <= I2CS_ST_ACKI;
                     end
                     else
                        drive_low_ff <= ~shift_ff[6] & ~transmit_clash_flag_ff;
                  end
               end
               I2CS_ST_ACKI:
               begin
                  if (scl_rise)
                     last_ack_seen_ff <= sda_s;
                  else if (scl_fall)
                     state_ff <= I2CS_ST_HOLD;
               end
               default:
                  state_ff <= I2CS_ST_IDLE;
            endcase
         end
      end
   end

   // status flags; hardware set wins over clear
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         data_done_flag_ff         <= 1'b0;
         addr_stop_flag_ff         <= 1'b0;
         flag_cause_bit_ff         <= 1'b0;
         transmit_clash_flag_ff    <= 1'b0;
         illegal_condition_flag_ff <= 1'b0;
      end
      else if (i_ce)
      begin
         // clearing paths
         if ((flag_wr && i_wdata[`I2CS_BIT_DDONE])
             || clr_irq)
            data_done_flag_ff <= 1'b0;
         if ((flag_wr && i_wdata[`I2CS_BIT_ASTOP])
             || clr_irq)
            addr_stop_flag_ff <= 1'b0;
         if ((i_wr && i_addr == `I2CS_OFS_FLAGS && i_wdata[`I2CS_BIT_CLASH])
             || start_ev)
            transmit_clash_flag_ff <= 1'b0;
         if (i_wr && i_addr == `I2CS_OFS_FLAGS && i_wdata[`I2CS_BIT_ILLEGAL_CONDITION_FLAG])
            illegal_condition_flag_ff <= 1'b0;
         // setting paths
         if (enabled && scl_fall && bit_cnt_ff == 4'h8 && state_ff == I2CS_ST_ADDR
             && addr_match)
         begin
            addr_stop_flag_ff <= 1'b1;
            flag_cause_bit_ff <= 1'b1;
         end
         // data done: byte received, byte sent, or read ack given
         if (enabled && ((scl_fall && bit_cnt_ff == 4'h8 && state_ff == I2CS_ST_RX)
             || (scl_fall && state_ff == I2CS_ST_ACKI)
             || (scl_fall && state_ff == I2CS_ST_ACKO && dir_ff
                 && bit_cnt_ff != 4'hF && !eff_ack)))
            data_done_flag_ff <= 1'b1;
         // stop flag on any stop while enabled with the stop-enable bit set, addressed or not
         if (enabled && stop_ev && setup_ff[`I2CS_BIT_STOPEN])
         begin
            addr_stop_flag_ff <= 1'b1;
            flag_cause_bit_ff <= 1'b0;
         end
         // line high while slave wants low is not a clash; want high, see low is
         if (enabled && scl_rise && sda_s == 1'b0 && !drive_low_ff
             && (state_ff == I2CS_ST_TX
                 || (state_ff == I2CS_ST_ACKO && eff_ack)))
            transmit_clash_flag_ff <= 1'b1;
         // bus error needs the master side enabled
         if (enabled && bus_err_ev)
            illegal_condition_flag_ff <= 1'b1;
      end
   end

   // status byte assembly
   assign flags = {data_done_flag_ff, addr_stop_flag_ff, stretch, last_ack_seen_ff,
                   transmit_clash_flag_ff, illegal_condition_flag_ff, dir_ff,
                   flag_cause_bit_ff};

   // read data one cycle after strobe
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_rdata <= 8'h00;
      else if (i_ce)
      begin
         if (!i_rd)
            o_rdata <= 8'h00;
         else
         begin
            case (i_addr)
               `I2CS_OFS_SETUP:   o_rdata <= setup_ff;
               `I2CS_OFS_CMDCTL:  o_rdata <= {5'h00, ack_choice_ff, 2'h0};
               `I2CS_OFS_FLAGS:   o_rdata <= flags;
               `I2CS_OFS_OWNADDR: o_rdata <= own_address_ff;
               `I2CS_OFS_DATA:    o_rdata <= shift_ff;
               default:           o_rdata <= 8'h00;
            endcase
         end
      end
   end

   // open-drain drive: low only
   assign o_scl    = 1'b0;
   assign o_sda    = 1'b0;
   assign o_scl_oe = stretch & enabled;
   assign o_sda_oe = drive_low_ff & enabled;
   assign o_data_irq      = setup_ff[`I2CS_BIT_DATA_IRQ_ENABLE] & data_done_flag_ff;
   assign o_addr_stop_irq = setup_ff[`I2CS_BIT_AIEN] & addr_stop_flag_ff;

endmodule
`default_nettype wire

// >>> sim/i2cs_slave_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "i2cs_consts.svh"
module i2cs_slave_chk
(
   // clock and register port
   input wire logic                 i_clk_sys,
   input wire logic                 i_rst_n,
   input wire logic                 i_ce,
   input wire i2cs_pkg::i2cs_addr_t i_addr,
   input wire logic [7:0]           i_wdata,
   input wire logic                 i_wr,
   input wire logic                 i_rd,
   input wire logic [7:0]           o_rdata,
   // bus lines and interrupts
   input wire logic                 i_scl,
   input wire logic                 i_sda,
   input wire logic                 o_scl,
   input wire logic                 o_scl_oe,
   input wire logic                 o_sda,
   input wire logic                 o_sda_oe,
   input wire logic                 i_master_en,
   input wire logic                 o_data_irq,
   input wire logic                 o_addr_stop_irq
);
   import i2cs_pkg::*;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   logic [7:0] setup_ff;
   // shadow of the setup register
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
         setup_ff <= 8'h00;
      else if (i_ce && i_wr && i_addr == `I2CS_OFS_SETUP)
         setup_ff <= i_wdata;
   end
   sequence s_cmd_exec;
      i_wr && i_ce && i_addr == `I2CS_OFS_CMDCTL && i_wdata[1] && o_scl_oe;
   endsequence
   sequence s_flag_read;
      i_rd && i_ce && i_addr == `I2CS_OFS_FLAGS;
   endsequence
   property p_rd_idle; !i_rd && i_ce |=> o_rdata == 8'h00; endproperty
   property p_cmd_rd0;
      i_rd && i_ce && i_addr == `I2CS_OFS_CMDCTL |=> o_rdata[1:0] == 2'b00;
   endproperty
   property p_ce_freeze;
      !i_ce |=> $stable(o_rdata) && $stable(o_scl_oe) && $stable(o_sda_oe);
   endproperty
   property p_hold_rd; s_flag_read |=> o_rdata[5] == $past(o_scl_oe); endproperty
   property p_as_rd; s_flag_read ##0 setup_ff[6] |=> o_rdata[6] == $past(o_addr_stop_irq);
   endproperty
   property p_open_drain; !o_scl && !o_sda; endproperty
   property p_dirq_en; o_data_irq |-> setup_ff[7]; endproperty
   property p_airq_en; o_addr_stop_irq |-> setup_ff[6]; endproperty
   property p_hold_en; $rose(o_scl_oe) |-> setup_ff[0]; endproperty
   property p_cmd_release; s_cmd_exec |-> ##[1:4] !o_scl_oe; endproperty
   property p_nop_hold;
      i_wr && i_addr == `I2CS_OFS_CMDCTL && i_wdata[1:0] == 2'b00 && o_scl_oe |=> o_scl_oe;
   endproperty
   property p_hold_stays; o_scl_oe && !i_wr && !i_rd |=> o_scl_oe; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle zero");
   a_cmd_rd0: assert property (p_cmd_rd0) else $error("command field read nonzero");
   a_hold_rd: assert property (p_hold_rd) else $error("stretch flag differs");
   a_as_rd: assert property (p_as_rd) else $error("addr stop flag differs");
   a_open_drain: assert property (p_open_drain) else $error("line driven high");
   a_dirq_en: assert property (p_dirq_en) else $error("data irq while disabled");
   a_airq_en: assert property (p_airq_en) else $error("addr irq while disabled");
   a_hold_en: assert property (p_hold_en) else $error("stretch while disabled");
   a_cmd_release: assert property (p_cmd_release) else $error("no release");
   a_nop_hold: assert property (p_nop_hold) else $error("no-op released bus");
   a_hold_stays: assert property (p_hold_stays) else $error("stretch dropped");
   a_ce_freeze: assert property (p_ce_freeze) else $error("moved while frozen");
endmodule
bind i2cs_slave i2cs_slave_chk u_chk (.i_clk_sys, .i_rst_n, .i_ce, .i_addr, .i_wdata, .i_wr,
   .i_rd, .o_rdata, .i_scl, .i_sda, .o_scl, .o_scl_oe, .o_sda, .o_sda_oe, .i_master_en,
   .o_data_irq, .o_addr_stop_irq);
`default_nettype wire

// >>> sim/i2cs_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module i2cs_bus_master
(
   // resolved lines
   input  wire logic i_scl,
   input  wire logic i_sda,
   // pulls and hang flag
   output var logic  o_scl_oe,
   output var logic  o_sda_oe,
   output var logic  o_stuck
);
   initial
   begin
      o_scl_oe = 1'b0;
      o_sda_oe = 1'b0;
      o_stuck = 1'b0;
   end
   // let scl rise, bounded wait on a stretch
   task automatic scl_up();
      int n;
      o_scl_oe = 1'b0;
      for (n = 0; n < 3000 && i_scl !== 1'b1; n++)
         #10;
      if (n == 3000)
         o_stuck = 1'b1;
   endtask
   // each phase held several system cycles
   task automatic bit_out(input logic b);
      o_sda_oe = !b;
      #31.25;
      scl_up();
      #62.5;
      o_scl_oe = 1'b1;
      #31.25;
   endtask
   task automatic bit_in(output logic b);
      o_sda_oe = 1'b0;
      #31.25;
      scl_up();
      #31.25;
      b = i_sda;
      #31.25;
      o_scl_oe = 1'b1;
      #31.25;
   endtask
   task automatic start();
      #62.5;
      o_sda_oe = 1'b1;
      #62.5;
      o_scl_oe = 1'b1;
      #31.25;
   endtask
   task automatic stop();
      o_sda_oe = 1'b1;
      #31.25;
      scl_up();
      #62.5;
      o_sda_oe = 1'b0;
      #62.5;
   endtask
   // msb first
   task automatic send_byte(input logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         bit_out(d[i]);
   endtask
   task automatic recv_byte(output logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         bit_in(d[i]);
   endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import i2cs_pkg::*;
   logic       clk, rst_n, wr, rd, men, ce, b, dirq, airq;
   logic       d_scl_oe, d_sda_oe, m_scl_oe, m_sda_oe, stuck;
   i2cs_addr_t addr;
   logic [7:0] wdata, rdata, got;
   int         miscompares, tests_run;
   // pulled-up open-drain lines
   wire logic  scl = !(m_scl_oe || d_scl_oe);
   wire logic  sda = !(m_sda_oe || d_sda_oe);
   i2cs_slave uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_scl(scl), .i_sda(sda),
      .o_scl(), .o_scl_oe(d_scl_oe), .o_sda(), .o_sda_oe(d_sda_oe), .i_master_en(men),
      .o_data_irq(dirq), .o_addr_stop_irq(airq));
   i2cs_bus_master m (.i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe),
      .o_stuck(stuck));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic finish_test();
      if (miscompares == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wrr(input i2cs_addr_t a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read, mask and compare
   task automatic rdr(input i2cs_addr_t a, input logic [7:0] e, input logic [7:0] k);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata & k, e);
   endtask
   task automatic wait_hold();
      int n;
      for (n = 0; n < 300 && d_scl_oe !== 1'b1; n++)
         @(posedge clk);
      if (n == 300)
      begin
         miscompares++;
         $display("Error %0t: no clock hold", $time);
         finish_test();
      end
   endtask
   initial
   begin
      {rst_n, wr, rd, addr, wdata, miscompares, tests_run} = '0;
      men = 1'b1;
      ce = 1'b1;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rdr(4'h9, 8'h00, 8'hFF);
      rdr(4'hA, 8'h00, 8'hFF);
      rdr(4'hB, 8'h00, 8'hFF);
      rdr(4'hE, 8'h00, 8'hFF);
      wrr(4'h9, 8'hE1);
      wrr(4'hC, 8'hA4);
      rdr(4'h9, 8'hE1, 8'hE7);
      // foreign address, then stop
      m.start();
      m.send_byte(8'h30);
      repeat (6) @(posedge clk);
      rdr(4'hB, 8'h00, 8'hED);
      m.bit_in(b);
      chk({7'h00, b}, 8'h01);
      m.stop();
      rdr(4'hB, 8'h40, 8'hED);
      chk({7'h00, airq}, 8'h01);
      wrr(4'hB, 8'h40);
      rdr(4'hB, 8'h00, 8'hED);
      // start straight into stop
      m.start();
      m.stop();
      rdr(4'hB, 8'h04, 8'h04);
      wrr(4'hB, 8'h44);
      rdr(4'hB, 8'h00, 8'hED);
      // same with the master side off: no bus error
      @(posedge clk) men <= 1'b0;
      m.start();
      m.stop();
      rdr(4'hB, 8'h40, 8'h44);
      wrr(4'hB, 8'h40);
      men <= 1'b1;
      // own address, master write, manual mode
      m.start();
      m.send_byte(8'hA4);
      wait_hold();
      rdr(4'hB, 8'h61, 8'hE3);
      chk({6'h00, airq, d_scl_oe}, 8'h03);
      // command while frozen is not taken
      @(posedge clk) ce <= 1'b0;
      wrr(4'hA, 8'h03);
      ce <= 1'b1;
      #1 chk({7'h00, d_scl_oe}, 8'h01);
      wrr(4'hA, 8'h04);
      rdr(4'hA, 8'h04, 8'hFF);
      chk({7'h00, d_scl_oe}, 8'h01);
      wrr(4'hA, 8'h03);
      m.bit_in(b);
      chk({7'h00, b}, 8'h00);
      m.send_byte(8'h5A);
      wait_hold();
      rdr(4'hB, 8'hA0, 8'hEC);
      chk({7'h00, dirq}, 8'h01);
      rdr(4'hD, 8'h5A, 8'hFF);
      chk({7'h00, d_scl_oe}, 8'h01);
      wrr(4'hA, 8'h06);
      m.bit_in(b);
      chk({7'h00, b}, 8'h01);
      rdr(4'hB, 8'h00, 8'hE0);
      m.stop();
      rdr(4'hB, 8'h40, 8'h41);
      wrr(4'hA, 8'h00);
      rdr(4'hB, 8'h40, 8'h41);
      wrr(4'hB, 8'h40);
      // any address, auto-continue, master read
      wrr(4'h9, 8'hE7);
      m.start();
      m.send_byte(8'h31);
      wait_hold();
      rdr(4'hB, 8'h63, 8'hE3);
      wrr(4'hA, 8'h03);
      m.bit_in(b);
      chk({7'h00, b}, 8'h00);
      wait_hold();
      rdr(4'hB, 8'hA0, 8'hA0);
      wrr(4'hD, 8'hC3);
      m.recv_byte(got);
      chk(got, 8'hC3);
      m.bit_out(1'b1);
      wait_hold();
      rdr(4'hB, 8'h90, 8'h90);
      wrr(4'hA, 8'h02);
      m.stop();
      rdr(4'hB, 8'h40, 8'h41);
      wrr(4'hB, 8'h40);
      // slave switched off
      wrr(4'h9, 8'h00);
      m.start();
      m.send_byte(8'hA4);
      repeat (6) @(posedge clk);
      chk({7'h00, d_scl_oe}, 8'h00);
      m.bit_in(b);
      chk({7'h00, b}, 8'h01);
      m.stop();
      rdr(4'hB, 8'h00, 8'hED);
      chk({7'h00, stuck}, 8'h00);
      finish_test();
   end
endmodule
`default_nettype wire
